// file: src/sclk_pkg.sv
// Constants and types for the switching clock sync and select block
// Overview of operation
// - Switching frequency 400 to 800 kHz, from strap or from a bus setting.
// - After reset the sync pin is an input and is not driven.
// - In input mode, an output enable assertion while not testing or locked starts an external clock test.
// - Once an external clock is found, switching cycles start on its rising edges.
// - While locked, an external period within 10 percent of the period measured at lock is followed, not divider steps.
// - On loss of lock, fall back to the internal oscillator at programmed frequency.
// - In output mode, run internally and drive the internal clock onto the pin.
// - In output mode, no external clock test on enable assertion.
// - Internal frequency is 16 MHz divided by a whole number from 20 to 40.
// - A bus request maps to the whole divisor nearest to 16000 kHz divided by the requested frequency.
// - Strap decode: open 400, high 485, resistors 432 to 800 kHz.
package sclk_pkg;

  localparam int MCLK_MHZ = 250;
  localparam int REF_MHZ  = 16;
  localparam int REF_KHZ  = 16000;

  localparam logic [9:0] FREQ_MIN_KHZ = 10'd400;
  localparam logic [9:0] FREQ_MAX_KHZ = 10'd800;
  localparam logic [5:0] DIV_MIN      = 6'h14;
  localparam logic [5:0] DIV_MAX      = 6'h28;

  // Period limits of an acceptable external clock
  localparam int PER_MIN_NS  = 1250;
  localparam int PER_MAX_NS  = 2500;
  localparam int PER_MIN_CYC = (PER_MIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int PER_MAX_CYC = (PER_MAX_NS * MCLK_MHZ) / 1000;
  localparam int TOL_NUM_HI  = 11;
  localparam int TOL_NUM_LO  = 9;
  localparam int TOL_DEN     = 10;

  localparam int CNT_W = 11;
  localparam int ACC_W = 14;

  // Strap codes as delivered by the strap sensing front end
  localparam logic [3:0] STRAP_OPEN  = 4'h0;
  localparam logic [3:0] STRAP_HIGH  = 4'h1;
  localparam logic [3:0] STRAP_R21K5 = 4'h2;
  localparam logic [3:0] STRAP_R23K7 = 4'h3;
  localparam logic [3:0] STRAP_R26K1 = 4'h4;
  localparam logic [3:0] STRAP_R28K7 = 4'h5;
  localparam logic [3:0] STRAP_R31K6 = 4'h6;
  localparam logic [3:0] STRAP_R34K8 = 4'h7;
  localparam logic [3:0] STRAP_R38K3 = 4'h8;

  // Divisors for 400, 485, 432, 457, 533, 571, 615, 727, 800 kHz
  localparam logic [5:0] DIV_400 = 6'h28;
  localparam logic [5:0] DIV_485 = 6'h21;
  localparam logic [5:0] DIV_432 = 6'h25;
  localparam logic [5:0] DIV_457 = 6'h23;
  localparam logic [5:0] DIV_533 = 6'h1E;
  localparam logic [5:0] DIV_571 = 6'h1C;
  localparam logic [5:0] DIV_615 = 6'h1A;
  localparam logic [5:0] DIV_727 = 6'h16;
  localparam logic [5:0] DIV_800 = 6'h14;

  localparam logic [5:0] DIV_RESET  = 6'h28;
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  typedef enum logic [1:0] {
    SCLK_INTERNAL = 2'b00,
    SCLK_DETECT   = 2'b01,
    SCLK_LOCKED   = 2'b11
  } sclk_state_e;

  typedef struct packed {
    logic       wr;
    logic [9:0] khz;
  } sclk_freq_req_s;

  typedef struct packed {
    logic       locked;
    logic       detecting;
    logic [5:0] divisor;
  } sclk_status_s;

endpackage

// file: src/sclk_sync_select.sv
// Switching clock generation with external sync detect, lock and fallback
`timescale 1ns/100ps
`default_nettype none
module sclk_sync_select (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    sync_i,
  output logic                         sync_o,
  output logic                         sync_oe,
  input  wire logic                    out_enable,
  input  wire logic [3:0]              freq_strap_resistor,
  input  wire logic                    sync_out_mode,
  input  wire sclk_pkg::sclk_freq_req_s switch_freq_setting,
  output logic                         switching_freq,
  output sclk_pkg::sclk_status_s       status
);

  logic [1:0]  sync_meta_r;
  logic [1:0]  en_meta_r;
  logic [7:0]  strap_meta_r;
  logic        sync_prev_r;
  logic        en_prev_r;

  sclk_pkg::sclk_state_e state_r, state_nxt;
  logic [sclk_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [sclk_pkg::CNT_W-1:0] ref_r, ref_nxt;
  logic        seen_r, seen_nxt;
  logic [sclk_pkg::ACC_W-1:0] acc_r, acc_nxt;
  logic [5:0]  div_r, div_nxt;
  logic [1:0]  strap_wait_r, strap_wait_nxt;
  logic        strap_done_r, strap_done_nxt;
  logic        pulse_r, pulse_nxt;
  logic        sync_o_r, sync_o_nxt;
  logic        sync_oe_r, sync_oe_nxt;
  logic        locked_r, locked_nxt;
  logic        detecting_r, detecting_nxt;

  logic        sync_rise;
  logic        en_rise;
  logic [5:0]  strap_div;
  logic [5:0]  bus_div;

  // Two flops on every pin input; only the second is read
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_meta_r  <= 2'h0;
      en_meta_r    <= 2'h0;
      strap_meta_r <= 8'h00;
      sync_prev_r  <= 1'b0;
      en_prev_r    <= 1'b0;
    end else begin
      sync_meta_r  <= {sync_meta_r[0], sync_i};
      en_meta_r    <= {en_meta_r[0], out_enable};
      strap_meta_r <= {strap_meta_r[3:0], freq_strap_resistor};
      sync_prev_r  <= sync_meta_r[1];
      en_prev_r    <= en_meta_r[1];
    end
  end

  assign sync_rise = sync_meta_r[1] & ~sync_prev_r;
  assign en_rise   = en_meta_r[1] & ~en_prev_r;

  // Strap table
  always_comb begin
    case (strap_meta_r[7:4])
      sclk_pkg::STRAP_OPEN:  strap_div = sclk_pkg::DIV_400;
      sclk_pkg::STRAP_HIGH:  strap_div = sclk_pkg::DIV_485;
      sclk_pkg::STRAP_R21K5: strap_div = sclk_pkg::DIV_432;
      sclk_pkg::STRAP_R23K7: strap_div = sclk_pkg::DIV_457;
      sclk_pkg::STRAP_R26K1: strap_div = sclk_pkg::DIV_533;
      sclk_pkg::STRAP_R28K7: strap_div = sclk_pkg::DIV_571;
      sclk_pkg::STRAP_R31K6: strap_div = sclk_pkg::DIV_615;
      sclk_pkg::STRAP_R34K8: strap_div = sclk_pkg::DIV_727;
      sclk_pkg::STRAP_R38K3: strap_div = sclk_pkg::DIV_800;
      default:               strap_div = sclk_pkg::DIV_400;
    endcase
  end

  // Nearest whole divisor: largest n with (2n-1)*f <= 2*16000
  always_comb begin
    int f;
    f = 0;
    bus_div = sclk_pkg::DIV_MIN;
    f = int'(switch_freq_setting.khz);
    if (f < int'(sclk_pkg::FREQ_MIN_KHZ)) begin
      f = int'(sclk_pkg::FREQ_MIN_KHZ);
    end
    if (f > int'(sclk_pkg::FREQ_MAX_KHZ)) begin
      f = int'(sclk_pkg::FREQ_MAX_KHZ);
    end
    for (int n = int'(sclk_pkg::DIV_MIN); n <= int'(sclk_pkg::DIV_MAX); n++) begin
      if ((2 * n - 1) * f <= 2 * sclk_pkg::REF_KHZ) begin
        bus_div = 6'(n);
      end
    end
  end

  always_comb begin
    int thr;
    int acc_sum;
    int per;
    thr            = 0;
    acc_sum        = 0;
    per            = 0;
    state_nxt      = state_r;
    cnt_nxt        = cnt_r;
    ref_nxt        = ref_r;
    seen_nxt       = seen_r;
    div_nxt        = div_r;
    strap_wait_nxt = strap_wait_r;
    strap_done_nxt = strap_done_r;
    pulse_nxt      = 1'b0;
    sync_oe_nxt    = sync_out_mode;

    // Divisor source: strap once, then bus writes
    if (switch_freq_setting.wr) begin
      div_nxt        = bus_div;
      strap_done_nxt = 1'b1;
    end else if (!strap_done_r) begin
      if (strap_wait_r == sclk_pkg::STRAP_WAIT) begin
        div_nxt        = strap_div;
        strap_done_nxt = 1'b1;
      end else begin
        strap_wait_nxt = strap_wait_r + 2'h1;
      end
    end

    // Internal oscillator: 16 MHz / N as a fractional accumulator on mclk
    thr     = sclk_pkg::MCLK_MHZ * int'(div_r);
    acc_sum = int'(acc_r) + sclk_pkg::REF_MHZ;
    if (acc_sum >= thr) begin
      acc_sum = acc_sum - thr;
    end
    acc_nxt = sclk_pkg::ACC_W'(acc_sum);
    // Square wave, high for the first half of each period
    // Gated by the mode here so the pin value comes straight from one flop
    sync_o_nxt = (2 * acc_sum < thr) && sync_out_mode;

    // Period counter saturates so a dead pin still times out
    if (sync_rise) begin
      cnt_nxt = '0;
    end else if (cnt_r != {sclk_pkg::CNT_W{1'b1}}) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    per = int'(cnt_r) + 1;

    case (state_r)
      sclk_pkg::SCLK_INTERNAL: begin
        pulse_nxt = (acc_sum == int'(acc_r) + sclk_pkg::REF_MHZ - thr);
        if (en_rise && !sync_out_mode) begin
          state_nxt = sclk_pkg::SCLK_DETECT;
          seen_nxt  = 1'b0;
          cnt_nxt   = '0;
        end
      end
      sclk_pkg::SCLK_DETECT: begin
        // Keep switching on the internal clock while testing
        pulse_nxt = (acc_sum == int'(acc_r) + sclk_pkg::REF_MHZ - thr);
        if (sync_out_mode) begin
          state_nxt = sclk_pkg::SCLK_INTERNAL;
        end else if (sync_rise) begin
          if (!seen_r) begin
            seen_nxt = 1'b1;
          end else if (per >= sclk_pkg::PER_MIN_CYC && per <= sclk_pkg::PER_MAX_CYC) begin
            state_nxt = sclk_pkg::SCLK_LOCKED;
            ref_nxt   = sclk_pkg::CNT_W'(per);
            pulse_nxt = 1'b1;
            acc_nxt   = '0;
          end else begin
            state_nxt = sclk_pkg::SCLK_INTERNAL;
          end
        end else if (int'(cnt_r) > sclk_pkg::PER_MAX_CYC) begin
          state_nxt = sclk_pkg::SCLK_INTERNAL;
        end
      end
      sclk_pkg::SCLK_LOCKED: begin
        // Edges follow the external clock; accumulator restarts for a clean fallback
        if (sync_out_mode) begin
          state_nxt = sclk_pkg::SCLK_INTERNAL;
        end else if (sync_rise) begin
          if (per * sclk_pkg::TOL_DEN <= int'(ref_r) * sclk_pkg::TOL_NUM_HI &&
              per * sclk_pkg::TOL_DEN >= int'(ref_r) * sclk_pkg::TOL_NUM_LO) begin
            pulse_nxt = 1'b1;
            acc_nxt   = '0;
          end else begin
            state_nxt = sclk_pkg::SCLK_INTERNAL;
          end
        end else if (int'(cnt_r) * sclk_pkg::TOL_DEN > int'(ref_r) * sclk_pkg::TOL_NUM_HI) begin
          state_nxt = sclk_pkg::SCLK_INTERNAL;
        end
      end
      default: begin
        state_nxt = sclk_pkg::SCLK_INTERNAL;
      end
    endcase
    locked_nxt    = (state_nxt == sclk_pkg::SCLK_LOCKED);
    detecting_nxt = (state_nxt == sclk_pkg::SCLK_DETECT);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r      <= sclk_pkg::SCLK_INTERNAL;
      cnt_r        <= '0;
      ref_r        <= '0;
      seen_r       <= 1'b0;
      acc_r        <= '0;
      div_r        <= sclk_pkg::DIV_RESET;
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
      pulse_r      <= 1'b0;
      sync_o_r     <= 1'b0;
      sync_oe_r    <= 1'b0;
      locked_r     <= 1'b0;
      detecting_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      ref_r        <= ref_nxt;
      seen_r       <= seen_nxt;
      acc_r        <= acc_nxt;
      div_r        <= div_nxt;
      strap_wait_r <= strap_wait_nxt;
      strap_done_r <= strap_done_nxt;
      pulse_r      <= pulse_nxt;
      sync_o_r     <= sync_o_nxt;
      sync_oe_r    <= sync_oe_nxt;
      locked_r     <= locked_nxt;
      detecting_r  <= detecting_nxt;
    end
  end

  assign switching_freq   = pulse_r;
  assign sync_o           = sync_o_r;
  assign sync_oe          = sync_oe_r;
  assign status.locked    = locked_r;
  assign status.detecting = detecting_r;
  assign status.divisor   = div_r;

endmodule
`default_nettype wire

// file: dv/sclk_sync_select_monitor.sv
// Port checker for the switching clock sync and select block
`timescale 1ns/100ps
`default_nettype none
module sclk_sync_select_monitor (
  input wire logic                     mclk,
  input wire logic                     reset,
  input wire logic                     sync_i,
  input wire logic                     sync_o,
  input wire logic                     sync_oe,
  input wire logic                     out_enable,
  input wire logic                     sync_out_mode,
  input wire sclk_pkg::sclk_freq_req_s switch_freq_setting,
  input wire logic                     switching_freq,
  input wire sclk_pkg::sclk_status_s   status
);
  logic [10:0] quiet_r;
  logic [10:0] quiet_nxt;
  logic        prev_r;
  // Cycles since the last sync pin rise, saturating so it never wraps
  always_comb begin
    quiet_nxt = (sync_i && !prev_r) ? 11'h000 : quiet_r + {10'h000, ~&quiet_r};
  end
  always_ff @(posedge mclk) begin
    quiet_r <= reset ? 11'h000 : quiet_nxt;
    prev_r  <= sync_i;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_reset_release: assert property ($fell(reset) |->
    !sync_oe && !status.locked && status.divisor == 6'h28) else $error("bad state after reset");
  chk_idle_pin: assert property (!sync_oe |-> !sync_o)
    else $error("sync pin active while released");
  chk_out_drive: assert property (sync_out_mode [*3] |-> sync_oe)
    else $error("sync pin not driven in output mode");
  chk_div_range: assert property (status.divisor >= 6'h14 && status.divisor <= 6'h28)
    else $error("divisor out of range");
  chk_bus_top: assert property (switch_freq_setting.wr && switch_freq_setting.khz >= 10'd800
    |=> status.divisor == 6'h14) else $error("high request not clamped");
  chk_bus_low: assert property (switch_freq_setting.wr && switch_freq_setting.khz <= 10'd400
    |=> status.divisor == 6'h28) else $error("low request not clamped");
  chk_detect_start: assert property ($rose(out_enable) && !sync_out_mode && !status.locked
    && !status.detecting |-> ##[1:5] status.detecting) else $error("no detect on enable");
  chk_out_no_detect: assert property (sync_out_mode [*4] |-> !status.detecting)
    else $error("detect in output mode");
  chk_lock_align: assert property (status.locked && $rose(sync_i) |->
    ##[1:6] (switching_freq || !status.locked)) else $error("cycle not aligned to sync rise");
  chk_pulse_single: assert property (switching_freq |=> !switching_freq)
    else $error("switching pulse too long");
  chk_loss_fallback: assert property (status.locked |-> quiet_r < 11'd720)
    else $error("still locked without sync clock");
endmodule
bind sclk_sync_select sclk_sync_select_monitor mon (.mclk, .reset, .sync_i, .sync_o, .sync_oe, .out_enable,
  .sync_out_mode, .switch_freq_setting, .switching_freq, .status);
`default_nettype wire

// file: dv/sclk_ext_clk.sv
// External sync clock source on the far side of the sync pin
`timescale 1ns/100ps
`default_nettype none
module sclk_ext_clk (
  input  wire logic run,
  input  var  int   half_ns,
  output logic      clk_out
);
  initial clk_out = 1'b0;
  // Only whole periods, so the rate never drifts while running
  always begin
    if (run) begin
      clk_out = 1'b1;
      #(half_ns);
      clk_out = 1'b0;
      #(half_ns);
    end else begin
      @(posedge run);
    end
  end
endmodule
`default_nettype wire

// file: dv/sclk_sync_select_tb.sv
// Self-checking testbench for the switching clock sync and select block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; $display("BAD %s exp %0d got %0d", n, e, s); end end
module sclk_sync_select_tb;
  logic                     mclk       = 1'b0;
  logic                     reset      = 1'b1;
  logic                     out_enable = 1'b0;
  logic                     out_mode   = 1'b0;
  logic [3:0]               strap      = 4'h0;
  sclk_pkg::sclk_freq_req_s req        = '0;
  logic                     ext_run    = 1'b0;
  int                       ext_half   = 940;
  int                       compares   = 0;
  int                       miscompares = 0;
  logic                     sync_o;
  logic                     sync_oe;
  logic                     sw;
  logic                     ext_clk;
  sclk_pkg::sclk_status_s   st;
  wire                      sync_pin;
  always #2 mclk = ~mclk;
  assign sync_pin = sync_oe ? sync_o : ext_clk;
  sclk_sync_select dut (.mclk(mclk), .reset(reset), .sync_i(sync_pin), .sync_o(sync_o), .sync_oe(sync_oe),
    .out_enable(out_enable), .freq_strap_resistor(strap), .sync_out_mode(out_mode),
    .switch_freq_setting(req), .switching_freq(sw), .status(st));
  sclk_ext_clk ext (.run(ext_run), .half_ns(ext_half), .clk_out(ext_clk));
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Waits for a pulse, then counts cycles until n more have come
  task automatic span(input int n, output int cyc);
    int k;
    k = 0;
    cyc = 0;
    while (sw !== 1'b1 && cyc < 2000) begin
      tick(1);
      cyc++;
    end
    cyc = 0;
    while (k < n && cyc < 20000) begin
      tick(1);
      cyc++;
      if (sw === 1'b1) k++;
    end
  endtask
  task automatic t_strap;
    logic [5:0] div [9] = '{6'h28, 6'h21, 6'h25, 6'h23, 6'h1E, 6'h1C, 6'h1A, 6'h16, 6'h14};
    for (int i = 0; i < 9; i++) begin
      strap = i[3:0];
      reset = 1'b1;
      tick(3);
      reset = 1'b0;
      tick(8);
      `CHK("strap divisor", div[i], st.divisor)
    end
    strap = 4'h3;
    tick(8);
    `CHK("strap held", 6'h14, st.divisor)
    $display("strap test done");
  endtask
  task automatic t_bus;
    logic [9:0] khz [6] = '{10'd810, 10'd390, 10'd600, 10'd700, 10'd457, 10'd500};
    logic [5:0] div [6] = '{6'h14, 6'h28, 6'h1B, 6'h17, 6'h23, 6'h20};
    int cyc;
    for (int i = 0; i < 6; i++) begin
      req = '{wr: 1'b1, khz: khz[i]};
      tick(1);
      `CHK("bus divisor", div[i], st.divisor)
    end
    req.wr = 1'b0;
    span(16, cyc);
    `CHK("internal period", 8000, cyc)
    $display("bus test done");
  endtask
  task automatic t_sync;
    int cyc;
    ext_run = 1'b1;
    tick(1200);
    out_enable = 1'b1;
    tick(6);
    `CHK("detecting", 1'b1, st.detecting)
    cyc = 0;
    while (st.locked !== 1'b1 && cyc < 2000) begin
      tick(1);
      cyc++;
    end
    `CHK("locked", 1'b1, st.locked)
    span(8, cyc);
    `CHK("external period", 3760, cyc)
    ext_run = 1'b0;
    out_enable = 1'b0;
    tick(1500);
    `CHK("fell back", 1'b0, st.locked)
    span(16, cyc);
    `CHK("programmed period", 8000, cyc)
    $display("sync test done");
  endtask
  task automatic t_out;
    int n;
    logic prev;
    out_mode = 1'b1;
    tick(3);
    `CHK("pin driven", 1'b1, sync_oe)
    out_enable = 1'b1;
    span(1, n);
    tick(10);
    n = 0;
    prev = sync_o;
    repeat (7900) begin
      tick(1);
      if (sync_o && !prev) n++;
      prev = sync_o;
    end
    `CHK("pin clocks", 15, n)
    `CHK("no detect", 1'b0, st.detecting)
    out_mode = 1'b0;
    out_enable = 1'b0;
    tick(3);
    `CHK("pin released", 1'b0, sync_oe)
    $display("output mode test done");
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    t_strap();
    t_bus();
    t_sync();
    t_out();
    results();
  end
  // Normal run is about 35k cycles; this allows near three times that
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
